// ---- psdm_pkg.sv ----
// How it works
// - With the page select low, byte writes and reads land in page 0, the pixels of commons 0 to 3.
// - With the page select high, the same byte addresses land in page 1, the pixels of commons 4 to 7.
// - A stored 1 lights the pixel at its segment and common crossing, a stored 0 leaves it dark.
// - The common and segment drive is produced from memory with no further software action.
// - Eight common outputs are driven, four per memory page.
package psdm_pkg;
  localparam int BYTE_W = 8;
  localparam int NUM_BYTES = 22;
  localparam int ADDR_W = 5;
  localparam int NUM_PAGES = 2;
  localparam int COMS_PER_PAGE = 4;
  localparam int NUM_COMS = 8;
  localparam int COM_W = 3;
  localparam int NUM_SEGS = 40;
  localparam int SEG_STRIDE = 40;
  localparam int PAGE_BITS = NUM_BYTES * BYTE_W;
  localparam int BIT_IDX_W = 8;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 5'h15;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [COM_W-1:0] LAST_COM = 3'h7;
  // Time each common stays selected, in microseconds
  localparam int COM_TIME_US = 500;
  localparam int CLK_MHZ = 10;
  localparam int COM_CYCLES = COM_TIME_US * CLK_MHZ;
  localparam int CNT_W = 16;
endpackage

// ---- psdm_scan_if.sv ----
`timescale 1ns/10ps
interface psdm_scan_if;
  import psdm_pkg::*;
  logic [COM_W-1:0] com_idx;
  logic pol;
  modport src (
    output com_idx,
    output pol
  );
  modport dst (
    input com_idx,
    input pol
  );
endinterface

// ---- psdm_scan.sv ----
`timescale 1ns/10ps
module psdm_scan #(
  parameter int COM_CYCLES = psdm_pkg::COM_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Scan state out
  psdm_scan_if.src scan
);
  import psdm_pkg::*;

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(COM_CYCLES - 1);

  logic [CNT_W-1:0] cnt_r;
  logic [COM_W-1:0] com_r;
  logic pol_r;
  logic step;

  assign step = (cnt_r == CNT_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (step) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Walk through all eight commons, free running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      com_r <= '0;
    end else if (step) begin
      com_r <= com_r + 1'b1;
    end
  end

  // Flip drive polarity every frame so the glass sees no DC
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pol_r <= 1'b0;
    end else if (step && com_r == LAST_COM) begin
      pol_r <= ~pol_r;
    end
  end

  assign scan.com_idx = com_r;
  assign scan.pol = pol_r;
endmodule

// ---- psdm_top.sv ----
`timescale 1ns/10ps
module psdm_top #(
  parameter int COM_CYCLES = psdm_pkg::COM_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Software write and read port
  input wire logic display_page_select,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [psdm_pkg::ADDR_W-1:0] addr,
  input wire logic [psdm_pkg::BYTE_W-1:0] wr_data,
  output logic [psdm_pkg::BYTE_W-1:0] rd_data,
  // Panel drive
  input wire logic drive_en,
  output logic [psdm_pkg::NUM_COMS-1:0] com_sel,
  output logic com_lvl,
  output logic [psdm_pkg::NUM_SEGS-1:0] seg_lvl
);
  import psdm_pkg::*;

  logic [BYTE_W-1:0] mem_r [NUM_PAGES][NUM_BYTES];
  logic [BYTE_W-1:0] rd_data_r;
  logic [NUM_COMS-1:0] com_sel_r;
  logic com_lvl_r;
  logic [NUM_SEGS-1:0] seg_r;
  logic [NUM_SEGS-1:0] seg_nxt;
  logic [PAGE_BITS-1:0] scan_page;
  logic addr_ok;
  logic page_idx;
  logic [1:0] com_in_page;

  psdm_scan_if scan_bus ();

  psdm_scan #(
    .COM_CYCLES(COM_CYCLES)
  ) u_scan (
    .clk(clk),
    .rst_n(rst_n),
    .scan(scan_bus)
  );

  // Addresses past the last data byte are ignored on write, read as zero
  assign addr_ok = (addr <= LAST_ADDR);

  // Page select steers the byte address to one page
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NUM_PAGES; p++) begin
        for (int b = 0; b < NUM_BYTES; b++) begin
          mem_r[p][b] <= BYTE_RST;
        end
      end
    end else if (wr_en && addr_ok) begin
      mem_r[display_page_select][addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= BYTE_RST;
    end else if (rd_en) begin
      rd_data_r <= addr_ok ? mem_r[display_page_select][addr] : BYTE_RST;
    end
  end

  // Upper common bit picks the page, lower two the common inside it
  assign page_idx = scan_bus.com_idx[COM_W-1];
  assign com_in_page = scan_bus.com_idx[1:0];

  always_comb begin
    for (int b = 0; b < NUM_BYTES; b++) begin
      scan_page[b*BYTE_W +: BYTE_W] = mem_r[page_idx][b];
    end
  end

  // Lit pixel drives its segment against the common, dark one with it
  always_comb begin
    logic [BIT_IDX_W-1:0] base;
    base = BIT_IDX_W'(SEG_STRIDE) * BIT_IDX_W'(com_in_page);
    for (int s = 0; s < NUM_SEGS; s++) begin
      seg_nxt[s] = scan_page[base + BIT_IDX_W'(s)] ^ ~scan_bus.pol;
    end
  end

  // Drive follows memory every scan step without software help
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      com_sel_r <= '0;
      com_lvl_r <= 1'b0;
      seg_r <= '0;
    end else if (drive_en) begin
      com_sel_r <= NUM_COMS'(1) << scan_bus.com_idx;
      com_lvl_r <= ~scan_bus.pol;
      seg_r <= seg_nxt;
    end else begin
      com_sel_r <= '0;
      com_lvl_r <= 1'b0;
      seg_r <= '0;
    end
  end

  assign rd_data = rd_data_r;
  assign com_sel = com_sel_r;
  assign com_lvl = com_lvl_r;
  assign seg_lvl = seg_r;
endmodule

// ---- psdm_monitor.sv ----
`timescale 1ns/10ps
module psdm_monitor (
  input logic clk,
  input logic rst_n,
  input logic display_page_select,
  input logic wr_en,
  input logic rd_en,
  input logic [4:0] addr,
  input logic [7:0] wr_data,
  input logic [7:0] rd_data,
  input logic drive_en,
  input logic [7:0] com_sel,
  input logic com_lvl,
  input logic [39:0] seg_lvl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(p);
    wr_en && addr < 5'h16 && display_page_select == p;
  endsequence
  sequence s_rd;
    rd_en && $stable(addr) && $stable(display_page_select);
  endsequence
  a_page_zero_rt:
    assert property (s_wr(0) ##1 s_rd |=> rd_data == $past(wr_data, 2))
    else $error("page 0 readback wrong");
  a_page_one_rt:
    assert property (s_wr(1) ##1 s_rd |=> rd_data == $past(wr_data, 2))
    else $error("page 1 readback wrong");
  a_read_hold:
    assert property (!rd_en |=> $stable(rd_data))
    else $error("read data moved without a read");
  a_blank_drive:
    assert property (!drive_en |=> com_sel == 8'h00 && seg_lvl == 40'h0)
    else $error("drive not blanked");
  a_com_onehot:
    assert property (drive_en ##1 drive_en |-> $onehot(com_sel))
    else $error("common select not one-hot");
  a_com_order:
    assert property ($changed(com_sel) && $past(com_sel) != 8'h00 &&
      com_sel != 8'h00 |-> com_sel == {$past(com_sel[6:0]), $past(com_sel[7])})
    else $error("commons out of order");
endmodule

// ---- psdm_panel.sv ----
`timescale 1ns/10ps
module psdm_panel (
  input logic clk,
  input logic [7:0] com_sel,
  input logic com_lvl,
  input logic [39:0] seg_lvl
);
  logic [39:0] lit [8];
  // Glass sees only the difference between segment and common
  always @(posedge clk)
    for (int c = 0; c < 8; c++)
      if (com_sel[c]) lit[c] <= seg_lvl ^ {40{com_lvl}};
endmodule

// ---- tb_paged_segment_display_memory.sv ----
`timescale 1ns/10ps
module tb_paged_segment_display_memory;
  logic clk = 1'b0;
  logic rst_n, display_page_select, wr_en, rd_en, drive_en, com_lvl;
  logic [4:0] addr;
  logic [7:0] wr_data, rd_data, com_sel;
  logic [39:0] seg_lvl;
  int miscompares = 0;
  int checked = 0;
  always #50 clk = ~clk;
  psdm_top #(.COM_CYCLES(4)) dut (.clk(clk), .rst_n(rst_n),
    .display_page_select(display_page_select), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
    .drive_en(drive_en), .com_sel(com_sel), .com_lvl(com_lvl),
    .seg_lvl(seg_lvl));
  psdm_panel panel (.clk(clk), .com_sel(com_sel), .com_lvl(com_lvl),
    .seg_lvl(seg_lvl));
  task automatic cmp(string n, logic [39:0] e, logic [39:0] s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(logic w, logic p, logic [4:0] a, logic [7:0] d);
    wr_en <= w;
    rd_en <= !w;
    display_page_select <= p;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
  endtask
  task automatic rd(logic p, logic [4:0] a, logic [7:0] e);
    acc(0, p, a, 8'h00);
    rd_en <= 1'b0;
    @(posedge clk);
    cmp("rd_data", {32'h0, e}, {32'h0, rd_data});
  endtask
  task automatic t_pages;
    acc(1, 1, 5'h00, 8'ha5);
    acc(1, 0, 5'h00, 8'h5a);
    rd(0, 5'h00, 8'h5a);
    rd(1, 5'h00, 8'ha5);
    acc(1, 1, 5'h05, 8'h08);
    rd(1, 5'h05, 8'h08);
    acc(1, 0, 5'h16, 8'hff);
    rd(0, 5'h16, 8'h00);
    $display("t_pages done");
  endtask
  task automatic t_panel;
    drive_en <= 1'b1;
    repeat (80) @(posedge clk);
    for (int c = 0; c < 8; c++)
      cmp("lit", c == 0 ? 40'h5a : c == 4 ? 40'ha5 : c == 5 ? 40'h8 : 40'h0,
        panel.lit[c]);
    drive_en <= 1'b0;
    repeat (2) @(posedge clk);
    #1 cmp("com_sel", 40'h0, {32'h0, com_sel});
    $display("t_panel done");
  endtask
  // Mid-run reset must clear both the stored pixels and the read byte
  task automatic t_reset;
    acc(1, 0, 5'h01, 8'h3c);
    rd(0, 5'h01, 8'h3c);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("rd_data", 40'h0, {32'h0, rd_data});
    rst_n <= 1'b1;
    rd(0, 5'h01, 8'h00);
    $display("t_reset done");
  endtask
  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {rst_n, display_page_select, wr_en, rd_en, drive_en} = 5'h00;
    addr = 5'h00;
    wr_data = 8'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_pages;
    t_panel;
    t_reset;
    stop_test;
  end
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    stop_test;
  end
endmodule
bind psdm_top psdm_monitor mon (.clk(clk), .rst_n(rst_n),
  .display_page_select(display_page_select), .wr_en(wr_en), .rd_en(rd_en),
  .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .drive_en(drive_en),
  .com_sel(com_sel), .com_lvl(com_lvl), .seg_lvl(seg_lvl));
